// File: inc/efi_pkg.sv
`default_nettype none
package efi_pkg;
    // Register addresses as seen by the configuration port
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  OFS_ENABLE_A     = 8'h03;
    localparam logic [7:0]  OFS_ENABLE_B     = 8'h04;
    localparam logic [7:0]  OFS_FLAGS_A      = 8'h05;
    localparam logic [7:0]  OFS_FLAGS_B      = 8'h06;
    localparam logic [7:0]  OFS_ROUTE_A      = 8'h07;
    localparam logic [7:0]  OFS_ROUTE_B      = 8'h08;
    // Flag count and split over the two byte registers
    localparam int          NUM_FLAGS        = 10;
    localparam int          LOW_BITS         = 8;
    localparam int          HIGH_BITS        = NUM_FLAGS - LOW_BITS;
    // Reset values
    localparam logic [NUM_FLAGS-1:0] ENABLE_RST = 10'h000;
    localparam logic [NUM_FLAGS-1:0] ROUTE_RST  = 10'h000;
    localparam logic [NUM_FLAGS-1:0] LATCH_RST  = 10'h000;
    // Route select encoding
    localparam logic        ROUTE_PRIMARY    = 1'b0;
    localparam logic        ROUTE_SECONDARY  = 1'b1;
endpackage
`default_nettype wire

// File: inc/efi_src_if.sv
`default_nettype none
// Synchronised source levels passed from the input stage to the flag logic
interface efi_src_if #(parameter int N = 10);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    modport producer (output level, output rise);
    modport consumer (input level, input rise);
endinterface
`default_nettype wire

// File: src/efi_sync.sv
`default_nettype none
// Three-stage synchroniser with edge detection for the monitored sources
module efi_sync
    import efi_pkg::*;
#(
    parameter int N = NUM_FLAGS
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [N-1:0] src_async,
    efi_src_if.producer      sout
);
    logic [N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [N-1:0] s1_next, s2_next, s3_next, lvl_next;

    // A level counts once stage two and three agree; stage one feeds only stage two
    always_comb begin
        s1_next  = src_async;
        s2_next  = s1_reg;
        s3_next  = s2_reg;
        lvl_next = lvl_reg;
        for (int i = 0; i < N; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    // Rise is a one-cycle pulse on the filtered level
    assign sout.level = lvl_reg;
    assign sout.rise  = lvl_next & ~lvl_reg;
endmodule
`default_nettype wire

// File: src/efi_unit.sv
//Contract
//- Primary request open-drain, active low
//- Ten flags across two flag registers
//- One enable bit per flag, two registers
//- Enabled flag latches rising edge, asserts request
//- Disabled flag mirrors level, no request
//- Writing one clears latched flag
//- Hardware or software reset clears flags
//- Route bit: 0 primary, 1 secondary
//- Any flags combine; secondary like primary
//- Flag write also clears latched source
`default_nettype none
module efi_unit
    import efi_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 soft_reset,
    input  wire logic [NUM_FLAGS-1:0] src_async,
    input  wire logic                 reg_wr,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic      [NUM_FLAGS-1:0] src_clear,
    output logic                      request_line_primary_o,
    output logic                      request_line_primary_oe,
    output logic                      request_line_secondary_o,
    output logic                      request_line_secondary_oe
);
    ////////////////////////////////////////////////////////////////////////
    efi_src_if #(.N(NUM_FLAGS)) src ();

    // Sources arrive from other clock domains inside the converter
    efi_sync #(.N(NUM_FLAGS)) u_sync (
        .clk       (clk),
        .nrst      (nrst),
        .src_async (src_async),
        .sout      (src)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [NUM_FLAGS-1:0] enable_reg, enable_next;
    logic [NUM_FLAGS-1:0] route_reg, route_next;
    logic [NUM_FLAGS-1:0] latch_reg, latch_next;
    logic [NUM_FLAGS-1:0] clr_reg, clr_next;
    logic [NUM_FLAGS-1:0] wr_clear;
    logic [7:0]           rdata_reg, rdata_next;
    logic                 req1_reg, req1_next, req2_reg, req2_next;
    logic [NUM_FLAGS-1:0] flag_view;

    // One-bits written to a flag register select the flags to clear
    always_comb begin
        wr_clear = '0;
        if (reg_wr && reg_addr == OFS_FLAGS_A) begin
            wr_clear[LOW_BITS-1:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == OFS_FLAGS_B) begin
            wr_clear[NUM_FLAGS-1:LOW_BITS] = reg_wdata[HIGH_BITS-1:0];
        end
    end

    // Configuration registers
    always_comb begin
        enable_next = enable_reg;
        route_next  = route_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_ENABLE_A: enable_next[LOW_BITS-1:0]           = reg_wdata;
                OFS_ENABLE_B: enable_next[NUM_FLAGS-1:LOW_BITS]   = reg_wdata[HIGH_BITS-1:0];
                OFS_ROUTE_A:  route_next[LOW_BITS-1:0]            = reg_wdata;
                OFS_ROUTE_B:  route_next[NUM_FLAGS-1:LOW_BITS]    = reg_wdata[HIGH_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Latches; a new edge in the clearing cycle wins so no event is lost
    always_comb begin
        latch_next = (latch_reg & ~wr_clear) | (src.rise & enable_reg);
        if (soft_reset) begin
            latch_next = LATCH_RST;
        end
        clr_next = wr_clear;
    end

    // Disabled flags show the live level and never reach a request line
    assign flag_view = (latch_reg & enable_reg) | (src.level & ~enable_reg);

    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            OFS_ENABLE_A: rdata_next = enable_reg[LOW_BITS-1:0];
            OFS_ENABLE_B: rdata_next = {6'h00, enable_reg[NUM_FLAGS-1:LOW_BITS]};
            OFS_FLAGS_A:  rdata_next = flag_view[LOW_BITS-1:0];
            OFS_FLAGS_B:  rdata_next = {6'h00, flag_view[NUM_FLAGS-1:LOW_BITS]};
            OFS_ROUTE_A:  rdata_next = route_reg[LOW_BITS-1:0];
            OFS_ROUTE_B:  rdata_next = {6'h00, route_reg[NUM_FLAGS-1:LOW_BITS]};
            default:      rdata_next = 8'h00;
        endcase
    end

    // Request lines: any enabled latched flag on that route pulls low
    // Built from next values so the line moves on the same edge as the latch
    always_comb begin
        req1_next = |(latch_next & enable_next & ~route_next);
        req2_next = |(latch_next & enable_next & route_next);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enable_reg <= ENABLE_RST;
            route_reg  <= ROUTE_RST;
            latch_reg  <= LATCH_RST;
            clr_reg    <= '0;
            rdata_reg  <= 8'h00;
            req1_reg   <= 1'b0;
            req2_reg   <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            route_reg  <= route_next;
            latch_reg  <= latch_next;
            clr_reg    <= clr_next;
            rdata_reg  <= rdata_next;
            req1_reg   <= req1_next;
            req2_reg   <= req2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open drain: data is always low, only the enable moves; pull-up is off chip
    assign request_line_primary_o    = 1'b0;
    assign request_line_primary_oe   = req1_reg;
    assign request_line_secondary_o  = 1'b0;
    assign request_line_secondary_oe = req2_reg;
    assign reg_rdata                 = rdata_reg;
    assign src_clear                 = clr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Request checks look at registered state, so a write in the same cycle cannot trip them
    property p_latch_set;
        @(posedge clk) disable iff (!nrst)
        (src.rise[0] && enable_reg[0] && !soft_reset) |=> latch_reg[0];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("enabled edge not latched");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!nrst)
        (enable_reg == '0) |-> !req1_reg && !req2_reg;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled flags drove a request");

    property p_mirror;
        @(posedge clk) disable iff (!nrst)
        (!enable_reg[0] && reg_addr == OFS_FLAGS_A) |=> reg_rdata[0] == $past(src.level[0]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("disabled flag not mirroring level");

    property p_w1c;
        @(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == OFS_FLAGS_A && reg_wdata[0] && !src.rise[0]) |=> !latch_reg[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    property p_w0_keep;
        @(posedge clk) disable iff (!nrst)
        (latch_reg[0] && reg_wr && reg_addr == OFS_FLAGS_A && !reg_wdata[0] && !soft_reset) |=> latch_reg[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("write zero changed flag");

    property p_soft_reset;
        @(posedge clk) disable iff (!nrst)
        soft_reset |=> latch_reg == '0;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left flags");

    property p_route;
        @(posedge clk) disable iff (!nrst)
        (latch_reg[0] && enable_reg[0] && route_reg[0]) |-> request_line_secondary_oe;
    endproperty
    a_route: assert property (p_route) else $error("secondary route not asserted");

    property p_release;
        @(posedge clk) disable iff (!nrst)
        !(|(latch_reg & enable_reg & ~route_reg)) |-> !request_line_primary_oe;
    endproperty
    a_release: assert property (p_release) else $error("primary held without cause");

    property p_src_clear;
        @(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == OFS_FLAGS_B && reg_wdata[0]) |=> src_clear[LOW_BITS];
    endproperty
    a_src_clear: assert property (p_src_clear) else $error("source clear missing");

    property p_primary_set;
        @(posedge clk) disable iff (!nrst)
        (|(latch_reg & enable_reg & ~route_reg)) |-> request_line_primary_oe;
    endproperty
    a_primary_set: assert property (p_primary_set) else $error("primary not held for latched flag");

    property p_secondary_release;
        @(posedge clk) disable iff (!nrst)
        !(|(latch_reg & enable_reg & route_reg)) |-> !request_line_secondary_oe;
    endproperty
    a_secondary_release: assert property (p_secondary_release) else $error("secondary held without cause");

    // A disabled flag must never start a latch, whatever its source does
    property p_no_latch_disabled;
        @(posedge clk) disable iff (!nrst)
        (!enable_reg[0] && !latch_reg[0]) |=> !latch_reg[0];
    endproperty
    a_no_latch_disabled: assert property (p_no_latch_disabled) else $error("disabled flag latched");

    // Clearing walk: the write of a one, then flag gone and source clear pulsed together
    sequence s_clear_flag0;
        reg_wr && reg_addr == OFS_FLAGS_A && reg_wdata[0] && !src.rise[0];
    endsequence

    sequence s_flag0_cleared;
        !latch_reg[0] && src_clear[0];
    endsequence

    property p_clear_walk;
        @(posedge clk) disable iff (!nrst)
        s_clear_flag0 |=> s_flag0_cleared;
    endproperty
    a_clear_walk: assert property (p_clear_walk) else $error("flag clear walk broken");
endmodule
`default_nettype wire

// File: test/efi_host_model.sv
`default_nettype none
// Host side of both request lines: the pull-ups make a released line read high
module efi_host_model (
    input  wire logic primary_oe,
    input  wire logic secondary_oe,
    output logic      primary_n,
    output logic      secondary_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // No other device shares the lines here, so only this unit can pull them low
    assign primary_n   = primary_oe ? 1'b0 : 1'b1;
    assign secondary_n = secondary_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: test/test_event_flag_interrupt_unit.sv
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t: %h", $time, a); end end
module test_event_flag_interrupt_unit import efi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk, nrst, soft_reset, reg_wr, p_o, p_oe, s_o, s_oe, p_n, s_n;
    logic [NUM_FLAGS-1:0] src_async, src_clear, en, rt, lat, clr_seen, f, e, r;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata, rd_val, m;
    int                   n_errors, num_checks;
    efi_unit i_dut (.clk(clk), .nrst(nrst), .soft_reset(soft_reset), .src_async(src_async), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_clear(src_clear),
        .request_line_primary_o(p_o), .request_line_primary_oe(p_oe), .request_line_secondary_o(s_o),
        .request_line_secondary_oe(s_oe));
    efi_host_model i_host (.primary_oe(p_oe), .secondary_oe(s_oe), .primary_n(p_n), .secondary_n(s_n));
    // Free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One-cycle write strobe; src_clear is sampled in the cycle after the write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        clr_seen = src_clear;
    endtask
    // Read data is registered, so it is taken one cycle after the address
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        rd_val = reg_rdata;
    endtask
    task automatic cfg(input logic [9:0] ev, input logic [9:0] rv);
        wr(OFS_ENABLE_A, ev[7:0]);
        wr(OFS_ENABLE_B, {6'h00, ev[9:8]});
        wr(OFS_ROUTE_A, rv[7:0]);
        wr(OFS_ROUTE_B, {6'h00, rv[9:8]});
        en = ev;
        rt = rv;
    endtask
    // Margin of six cycles covers the three-stage synchroniser plus the latch
    task automatic set_src(input logic [9:0] v);
        @(negedge clk);
        lat = lat | (en & v & ~src_async);
        src_async = v;
        repeat (6) @(negedge clk);
    endtask
    function automatic logic [9:0] exp_flags(input logic [9:0] lvl);
        return (en & lat) | (~en & lvl);
    endfunction
    task automatic chk_state(input logic [9:0] lvl);
        rd(OFS_FLAGS_A);
        f[7:0] = rd_val;
        rd(OFS_FLAGS_B);
        f[9:8] = rd_val[1:0];
        `CHK(f, exp_flags(lvl))
        `CHK(rd_val[7:2], 6'h00)
        `CHK(p_n, ~|(en & lat & ~rt))
        `CHK(s_n, ~|(en & lat & rt))
        `CHK({p_o, s_o}, 2'b00)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {nrst, soft_reset, reg_wr, src_async, reg_addr, reg_wdata} = '0;
        {en, rt, lat, n_errors, num_checks} = '0;
        void'($urandom(32'h0d699142));
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        // Every mapped register clears; unmapped neighbours read zero
        for (int a = 2; a < 10; a++) begin
            rd(8'(a));
            `CHK(rd_val, 8'h00)
        end
        $display("test reset done");
        set_src(10'($urandom));
        chk_state(src_async);
        set_src(10'h000);
        chk_state(10'h000);
        $display("test mirror done");
        // Latch, route and hold, with all-primary and all-secondary corners
        for (int i = 0; i < 8; i++) begin
            e = (i < 2) ? 10'h3ff : 10'($urandom);
            r = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
            cfg(e, r);
            set_src(10'($urandom));
            chk_state(src_async);
            set_src(10'h000);
            chk_state(10'h000);
            wr(OFS_FLAGS_A, 8'hff);
            wr(OFS_FLAGS_B, 8'h03);
            lat = '0;
        end
        $display("test latch done");
        // Service order: disable, watch live level, remove cause, write zero, re-enable, clear
        cfg(10'h3ff, 10'($urandom));
        set_src(10'h3ff);
        cfg(10'h000, rt);
        chk_state(10'h3ff);
        set_src(10'h000);
        chk_state(10'h000);
        wr(OFS_FLAGS_A, 8'h00);
        `CHK(clr_seen, 10'h000)
        cfg(10'h3ff, rt);
        chk_state(10'h000);
        m = 8'($urandom);
        wr(OFS_FLAGS_A, m);
        `CHK(clr_seen, {2'b00, m})
        lat = lat & ~{2'b00, m};
        chk_state(10'h000);
        wr(OFS_FLAGS_B, 8'h03);
        `CHK(clr_seen, 10'h300)
        lat = lat & 10'h0ff;
        chk_state(10'h000);
        $display("test clear done");
        // Software reset, then hardware reset in mid-run, both drop latched flags
        set_src(10'h3ff);
        @(negedge clk);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        lat = '0;
        chk_state(10'h3ff);
        set_src(10'h000);
        set_src(10'h3ff);
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        {en, rt, lat} = '0;
        repeat (6) @(negedge clk);
        chk_state(10'h3ff);
        // Re-enable with the source held high: a latch left over from before reset would show
        cfg(10'h3ff, 10'h000);
        chk_state(10'h3ff);
        $display("test resets done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
